//--- rtl/wold_detector.sv
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module wold_detector #(
  parameter int NUM_TYPES = wold_pkg::NUM_TYPES  // Custom frame types
) (
  input  wire logic                        clk_sys,        // System clock
  input  wire logic                        reset,          // Synchronous reset, high
  input  wire wold_pkg::wold_req_t         regReq,         // Register write/read request
  output logic [wold_pkg::DATA_W-1:0]      regRdata,       // Read data, cycle after read
  input  wire wold_pkg::wold_rx_t          rxByte,         // Received frame bytes
  input  wire logic                        linkUp,         // Link status level
  input  wire logic                        indicatorFunc,  // Normal indicator pin level
  input  wire logic                        irqFunc_n,      // Normal interrupt pin level
  output logic                             indicatorPinOne, // Indicator pin level
  output logic                             wakeOutOnIrqPin  // Interrupt pin level
);

  // State of the detector, apart from the CRC accumulators held in the wold_crc_unit instances
  typedef struct packed {
    logic [15:0]                wakeCtrl;
    logic [15:0]                stationAddrLow;
    logic [15:0]                stationAddrMid;
    logic [15:0]                stationAddrHigh;
    logic                       magicSeen;
    logic                       linkUpSeen;
    logic                       linkDownSeen;
    logic                       routeLed;
    logic                       routeIrq;
    logic                       irqInvert;
    logic                       enhLed;
    logic [NUM_TYPES-1:0][31:0] crcExp;
    logic [NUM_TYPES-1:0][63:0] byteMask;
    logic                       latchMagic;
    logic                       latchUp;
    logic                       latchDown;
    logic [NUM_TYPES-1:0]       latchCustom;
    logic                       linkPrev;
    wold_pkg::wold_magic_t      magicState;
    logic [2:0]                 syncCnt;
    logic [2:0]                 addrIdx;
    logic [3:0]                 repCnt;
    logic [6:0]                 byteCnt;
    logic                       checkPend;
    logic [15:0]                rdData;
    logic                       ledPin;
    logic                       irqPin;
  } wold_state_t;

  wold_state_t s;
  wold_state_t n;

  logic [NUM_TYPES-1:0][31:0] crcOut;
  logic [NUM_TYPES-1:0]       crcInclude;
  logic [6:0]                 byteIdx;
  logic [47:0]                stationAddr;
  logic                       upEvt;
  logic                       downEvt;
  logic                       frameWake;
  logic                       linkWake;
  logic                       allWake;
  logic                       ledWake;
  logic                       irqWake;

  // Position of the current byte in its frame
  assign byteIdx = rxByte.first ? 7'h00 : s.byteCnt;
  assign stationAddr = {s.stationAddrHigh, s.stationAddrMid, s.stationAddrLow}; // R5

  // One CRC accumulator per custom frame type
  genvar t;
  generate
    for (t = 0; t < NUM_TYPES; t++) begin : gType
      assign crcInclude[t] = (byteIdx < wold_pkg::MASK_BYTES) &&
                             s.byteMask[t][byteIdx[5:0]]; // R8 R10
      wold_crc_unit uCrc (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .byteValid  (rxByte.valid),
        .frameStart (rxByte.first),
        .byteSel    (crcInclude[t]),
        .byteData   (rxByte.data),
        .crcValue   (crcOut[t])
      );
    end
  endgenerate

  // Byte k of the station address, first byte on the wire is k = 0
  function automatic logic [7:0] addrByte(input logic [47:0] a, input logic [2:0] k);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 6; i++) begin
      if (k == i[2:0]) begin
        r = a[8*(5-i) +: 8];
      end
    end
    return r;
  endfunction

  // Read value for an address
  function automatic logic [15:0] readValue(input wold_state_t c, input logic [7:0] a);
    logic [15:0] r;
    logic [7:0]  ofs;
    int          ty;
    r   = 16'h0000;
    ofs = a - wold_pkg::OFS_TYPE_BASE;
    ty  = int'(ofs[4:3]);
    unique case (a)
      wold_pkg::OFS_WAKE_CTRL:  r = c.wakeCtrl;
      wold_pkg::OFS_ADDR_LOW:   r = c.stationAddrLow;
      wold_pkg::OFS_ADDR_MID:   r = c.stationAddrMid;
      wold_pkg::OFS_ADDR_HIGH:  r = c.stationAddrHigh;
      wold_pkg::OFS_MAGIC_STAT: r = {15'h0000, c.magicSeen}; // R7
      wold_pkg::OFS_LINK_STAT:  r = {14'h0000, c.linkDownSeen, c.linkUpSeen}; // R15
      wold_pkg::OFS_ROUTE:      r = {14'h0000, c.routeIrq, c.routeLed};
      wold_pkg::OFS_PIN_CTRL:   r = {14'h0000, c.enhLed, c.irqInvert};
      wold_pkg::OFS_WAKE_STAT:  r = {9'h000, c.latchCustom, c.latchDown, c.latchUp,
                                     c.latchMagic};
      default: begin
        if (a >= wold_pkg::OFS_TYPE_BASE && ofs < wold_pkg::TYPE_SPAN && ty < NUM_TYPES) begin
          unique case (ofs[2:0])
            wold_pkg::SUB_CRC_LO: r = c.crcExp[ty][15:0];  // R12
            wold_pkg::SUB_CRC_HI: r = c.crcExp[ty][31:16]; // R12
            3'h2:                 r = c.byteMask[ty][15:0]; // R13
            3'h3:                 r = c.byteMask[ty][31:16];
            3'h4:                 r = c.byteMask[ty][47:32];
            3'h5:                 r = c.byteMask[ty][63:48];
            default:              r = 16'h0000;
          endcase
        end
      end
    endcase
    return r;
  endfunction

  // Next state: registers, detectors, wake latches and pins
  always_comb begin
    wold_pkg::wold_magic_t st;
    logic [2:0]  sc;
    logic [2:0]  ai;
    logic [3:0]  rc;
    logic [7:0]  b;
    logic [7:0]  ofs;
    int          ty;
    logic        magicHit;
    logic [NUM_TYPES-1:0] customHit;
    logic        wrSt;
    st        = s.magicState;
    sc        = s.syncCnt;
    ai        = s.addrIdx;
    rc        = s.repCnt;
    b         = rxByte.data;
    ofs       = regReq.addr - wold_pkg::OFS_TYPE_BASE;
    ty        = int'(ofs[4:3]);
    magicHit  = 1'b0;
    customHit = '0;
    wrSt      = 1'b0;
    n         = s;

    // Register writes
    if (regReq.wr) begin
      unique case (regReq.addr)
        wold_pkg::OFS_WAKE_CTRL: n.wakeCtrl = regReq.wdata; // R4 R11
        wold_pkg::OFS_ADDR_LOW:  n.stationAddrLow  = regReq.wdata; // R5
        wold_pkg::OFS_ADDR_MID:  n.stationAddrMid  = regReq.wdata; // R5
        wold_pkg::OFS_ADDR_HIGH: n.stationAddrHigh = regReq.wdata; // R5
        wold_pkg::OFS_MAGIC_STAT: begin
          if (regReq.wdata[0]) n.magicSeen = 1'b0;
        end
        wold_pkg::OFS_LINK_STAT: begin
          if (regReq.wdata[wold_pkg::BIT_LINK_UP_SEEN]) n.linkUpSeen = 1'b0;
          if (regReq.wdata[wold_pkg::BIT_LINK_DN_SEEN]) n.linkDownSeen = 1'b0;
        end
        wold_pkg::OFS_ROUTE: begin
          n.routeLed = regReq.wdata[wold_pkg::BIT_ROUTE_LED]; // R16
          n.routeIrq = regReq.wdata[wold_pkg::BIT_ROUTE_IRQ]; // R16
        end
        wold_pkg::OFS_PIN_CTRL: begin
          n.irqInvert = regReq.wdata[wold_pkg::BIT_IRQ_INVERT]; // R20
          n.enhLed    = regReq.wdata[wold_pkg::BIT_ENH_LED];
        end
        default: wrSt = 1'b1;
      endcase
      if (wrSt && regReq.addr >= wold_pkg::OFS_TYPE_BASE && ofs < wold_pkg::TYPE_SPAN &&
          ty < NUM_TYPES) begin
        unique case (ofs[2:0])
          wold_pkg::SUB_CRC_LO: n.crcExp[ty][15:0]    = regReq.wdata; // R12
          wold_pkg::SUB_CRC_HI: n.crcExp[ty][31:16]   = regReq.wdata; // R12
          3'h2:                 n.byteMask[ty][15:0]  = regReq.wdata; // R13
          3'h3:                 n.byteMask[ty][31:16] = regReq.wdata; // R13
          3'h4:                 n.byteMask[ty][47:32] = regReq.wdata; // R13
          3'h5:                 n.byteMask[ty][63:48] = regReq.wdata; // R13
          default:              n.byteMask[ty]        = s.byteMask[ty];
        endcase
      end
    end

    // Read data valid only in the cycle after the strobe
    n.rdData = regReq.rd ? readValue(s, regReq.addr) : 16'h0000;

    // Magic frame search over the receive stream, receive only
    if (rxByte.valid) begin // R6
      if (rxByte.first) begin
        st = wold_pkg::MG_SYNC;
        sc = 3'h0;
        ai = 3'h0;
        rc = 4'h0;
      end
      unique case (st)
        wold_pkg::MG_SYNC: begin
          if (b == wold_pkg::SYNC_BYTE) begin
            if (sc != wold_pkg::SYNC_LEN) sc = sc + 3'h1; // R2
          end else if (sc == wold_pkg::SYNC_LEN && b == addrByte(stationAddr, 3'h0)) begin
            st = wold_pkg::MG_ADDR;
            ai = 3'h1;
            rc = 4'h0;
          end else begin
            sc = 3'h0; // R23
          end
        end
        wold_pkg::MG_ADDR: begin
          if (b == addrByte(stationAddr, ai)) begin
            if (ai == wold_pkg::ADDR_LAST_IDX) begin
              ai = 3'h0;
              if (rc == wold_pkg::ADDR_LAST_REP) st = wold_pkg::MG_DONE; // R2
              else rc = rc + 4'h1;
            end else begin
              ai = ai + 3'h1;
            end
          end else begin
            st = wold_pkg::MG_SYNC; // R23
            sc = (b == wold_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
        wold_pkg::MG_DONE: st = wold_pkg::MG_DONE;
      endcase
      magicHit     = rxByte.last && (st == wold_pkg::MG_DONE);
      n.byteCnt    = (byteIdx < wold_pkg::MASK_BYTES) ? byteIdx + 7'h01 : byteIdx;
      n.checkPend  = rxByte.last;
    end else begin
      n.checkPend  = 1'b0;
    end
    n.magicState = st;
    n.syncCnt    = sc;
    n.addrIdx    = ai;
    n.repCnt     = rc;

    // Compare the finished CRCs one cycle after the last byte
    for (int k = 0; k < NUM_TYPES; k++) begin
      customHit[k] = s.checkPend && (crcOut[k] == s.crcExp[k]); // R9
    end

    // Link transitions
    n.linkPrev = linkUp;
    upEvt      = linkUp && !s.linkPrev;
    downEvt    = !linkUp && s.linkPrev;

    // Sticky status, a new event wins over a clear in the same cycle
    if (magicHit) n.magicSeen = 1'b1; // R7
    if (upEvt) n.linkUpSeen = 1'b1; // R15
    if (downEvt) n.linkDownSeen = 1'b1; // R15

    // Wake latches held while enabled, dropped when the enable clears
    n.latchMagic = n.wakeCtrl[wold_pkg::BIT_MAGIC_EN] &&
                   (s.latchMagic || magicHit); // R3 R18
    n.latchUp    = n.wakeCtrl[wold_pkg::BIT_LINK_UP_EN] && (s.latchUp || upEvt); // R14 R18
    n.latchDown  = n.wakeCtrl[wold_pkg::BIT_LINK_DOWN_EN] &&
                   (s.latchDown || downEvt); // R14 R18
    for (int k = 0; k < NUM_TYPES; k++) begin
      n.latchCustom[k] = n.wakeCtrl[wold_pkg::BIT_CUSTOM_EN0 + k] &&
                         (s.latchCustom[k] || customHit[k]); // R10 R11 R18
    end

    // Source grouping per pin
    frameWake = s.latchMagic || (|s.latchCustom);
    linkWake  = s.latchUp || s.latchDown;
    allWake   = frameWake || linkWake; // R1
    unique case (s.wakeCtrl[wold_pkg::POS_OUT_SEL +: 2]) // R17
      wold_pkg::SEL_ALL_BOTH: begin
        ledWake = allWake;
        irqWake = allWake;
      end
      wold_pkg::SEL_FRAME_LED: begin
        ledWake = frameWake;
        irqWake = linkWake;
      end
      wold_pkg::SEL_LINK_LED: begin
        ledWake = linkWake;
        irqWake = frameWake;
      end
      wold_pkg::SEL_MAGIC_LED: begin
        ledWake = s.latchMagic;
        irqWake = (|s.latchCustom) || linkWake;
      end
    endcase

    // Pin levels when routed: active-low wake on the indicator pin, irqInvert sets the interrupt pin polarity; normal function otherwise
    n.ledPin = s.routeLed ? !ledWake : indicatorFunc; // R16 R19
    n.irqPin = s.routeIrq ? (irqWake ^ !s.irqInvert) : irqFunc_n; // R16 R19 R20
  end

  // State register, everything disabled after reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s                 <= '0;
      s.wakeCtrl        <= wold_pkg::RST_WAKE_CTRL; // R1
      s.stationAddrLow  <= wold_pkg::RST_ADDR;
      s.stationAddrMid  <= wold_pkg::RST_ADDR;
      s.stationAddrHigh <= wold_pkg::RST_ADDR;
      s.crcExp          <= {NUM_TYPES{wold_pkg::RST_CRC_EXP}};
      s.byteMask        <= {NUM_TYPES{wold_pkg::RST_MASK}};
      s.magicState      <= wold_pkg::MG_SYNC;
      s.ledPin          <= 1'b1;
      s.irqPin          <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata        = s.rdData;
  assign indicatorPinOne = s.ledPin;
  assign wakeOutOnIrqPin = s.irqPin;

endmodule

//--- rtl/wold_pkg.sv
// Behaviour
// R1 - After reset all wake sources are off and no wake output is raised.
// R2 - A magic frame is six 0xFF bytes then sixteen copies of the station address.
// R3 - An enabled magic frame drives the wake output low.
// R4 - Software sets the magic enable bit before expecting magic wake events.
// R5 - Software writes the station address in three registers; the block holds them.
// R6 - The block only detects magic frames and never sends them.
// R7 - A detected magic frame is recorded in a readable status register.
// R8 - Per type, a byte mask picks which of the first 64 bytes feed the CRC.
// R9 - At frame end the masked CRC is compared with the expected value; match wakes.
// R10 - Four independent custom frame types, each with own enable, CRC and mask.
// R11 - Wake control bits two to five enable custom types zero to three.
// R12 - Each expected CRC is 32 bits held as low and high halves.
// R13 - Each 64-bit byte mask is held in four quarter registers.
// R14 - Enabled link-up or link-down transitions drive the wake output low.
// R15 - Link change status is readable in the interrupt status register.
// R16 - Wake appears on the indicator pin or interrupt pin, each route enabled.
// R17 - An output-select field decides which sources drive each wake pin.
// R18 - Wake stays asserted until the triggering source enable is cleared.
// R19 - The wake output is active low.
// R20 - On the interrupt pin the wake polarity follows the polarity invert bit.
// R21 - Software keeps enhanced indicator mode off while wake uses the indicator pin.
// R22 - The custom CRC is the standard Ethernet CRC-32 with reflected bit order.
// R23 - Magic matching restarts on any break so sync may appear anywhere.
package wold_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_WAKE_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ADDR_LOW    = 8'h01;
  localparam logic [7:0] OFS_ADDR_MID    = 8'h02;
  localparam logic [7:0] OFS_ADDR_HIGH   = 8'h03;
  localparam logic [7:0] OFS_MAGIC_STAT  = 8'h04;
  localparam logic [7:0] OFS_LINK_STAT   = 8'h05;
  localparam logic [7:0] OFS_ROUTE       = 8'h06;
  localparam logic [7:0] OFS_PIN_CTRL    = 8'h07;
  localparam logic [7:0] OFS_WAKE_STAT   = 8'h08;
  localparam logic [7:0] OFS_TYPE_BASE   = 8'h10;
  localparam logic [7:0] TYPE_SPAN       = 8'h20;
  localparam logic [2:0] SUB_CRC_LO      = 3'h0;
  localparam logic [2:0] SUB_CRC_HI      = 3'h1;
  localparam logic [2:0] SUB_MASK_Q0     = 3'h2;
  localparam logic [2:0] SUB_MASK_Q3     = 3'h5;

  // Field positions
  localparam int BIT_LINK_UP_EN   = 0;
  localparam int BIT_LINK_DOWN_EN = 1;
  localparam int BIT_CUSTOM_EN0   = 2;
  localparam int BIT_MAGIC_EN     = 6;
  localparam int POS_OUT_SEL      = 7;
  localparam int BIT_ROUTE_LED    = 0;
  localparam int BIT_ROUTE_IRQ    = 1;
  localparam int BIT_IRQ_INVERT   = 0;
  localparam int BIT_ENH_LED      = 1;
  localparam int BIT_LINK_UP_SEEN = 0;
  localparam int BIT_LINK_DN_SEEN = 1;

  // Reset values
  localparam logic [15:0] RST_WAKE_CTRL = 16'h0000;
  localparam logic [15:0] RST_ADDR      = 16'h0000;
  localparam logic [31:0] RST_CRC_EXP   = 32'h0000_0000;
  localparam logic [63:0] RST_MASK      = 64'h0000_0000_0000_0000;

  // Magic frame shape
  localparam logic [7:0] SYNC_BYTE     = 8'hFF;
  localparam logic [2:0] SYNC_LEN      = 3'h6;
  localparam logic [2:0] ADDR_LAST_IDX = 3'h5;
  localparam logic [3:0] ADDR_LAST_REP = 4'hF;

  // Custom frame CRC
  localparam int          NUM_TYPES  = 4;
  localparam logic [6:0]  MASK_BYTES = 7'h40;
  localparam logic [31:0] CRC_POLY   = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT   = 32'hFFFF_FFFF;

  // Output-select codes
  localparam logic [1:0] SEL_ALL_BOTH  = 2'h0;
  localparam logic [1:0] SEL_FRAME_LED = 2'h1;
  localparam logic [1:0] SEL_LINK_LED  = 2'h2;
  localparam logic [1:0] SEL_MAGIC_LED = 2'h3;

  // Received byte stream from the receive path
  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } wold_rx_t;

  // Register port request
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } wold_req_t;

  // Magic frame search states
  typedef enum logic [1:0] {
    MG_SYNC,
    MG_ADDR,
    MG_DONE
  } wold_magic_t;

endpackage

//--- rtl/wold_crc_unit.sv
`timescale 1ns/10ps
module wold_crc_unit (
  input  wire logic        clk_sys,     // System clock
  input  wire logic        reset,       // Synchronous reset
  input  wire logic        byteValid,   // Byte present this cycle
  input  wire logic        frameStart,  // Byte is first of frame
  input  wire logic        byteSel,     // Byte selected by mask
  input  wire logic [7:0]  byteData,    // Byte value
  output logic      [31:0] crcValue     // Final CRC of bytes so far
);

  typedef struct packed {
    logic [31:0] crc;
  } wold_crc_state_t;

  wold_crc_state_t s;
  wold_crc_state_t n;

  // Reflected CRC-32 over one byte, least significant bit first
  function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h00_0000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ wold_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Restart at frame start, fold in selected bytes only
  always_comb begin
    logic [31:0] base;
    base = frameStart ? wold_pkg::CRC_INIT : s.crc;
    n = s;
    if (byteValid) begin
      n.crc = byteSel ? crcByte(base, byteData) : base; // R8 R22
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s.crc <= wold_pkg::CRC_INIT;
    end else begin
      s <= n;
    end
  end

  // Final complement as for the Ethernet frame check
  assign crcValue = ~s.crc; // R22

endmodule

//--- dv/wold_detector_asserts.sv
`timescale 1ns/10ps
module wold_checker #(
  parameter int NUM_TYPES = wold_pkg::NUM_TYPES  // Custom frame types
) (
  input wire logic                        clk_sys,         // System clock
  input wire logic                        reset,           // Synchronous reset
  input wire wold_pkg::wold_req_t         regReq,          // Register request
  input wire logic [wold_pkg::DATA_W-1:0] regRdata,        // Read data
  input wire wold_pkg::wold_rx_t          rxByte,          // Received bytes
  input wire logic                        linkUp,          // Link level
  input wire logic                        indicatorFunc,   // Normal indicator level
  input wire logic                        irqFunc_n,       // Normal interrupt level
  input wire logic                        indicatorPinOne, // Indicator pin
  input wire logic                        wakeOutOnIrqPin  // Interrupt pin
);
  logic [15:0] ctrl_ff;
  logic [1:0]  route_ff;
  logic        invert_ff;

  // Shadow of what software wrote, so pin levels can be predicted
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_ff   <= 16'h0000;
      route_ff  <= 2'h0;
      invert_ff <= 1'b0;
    end else if (regReq.wr) begin
      if (regReq.addr == wold_pkg::OFS_WAKE_CTRL) ctrl_ff <= regReq.wdata;
      if (regReq.addr == wold_pkg::OFS_ROUTE) route_ff <= regReq.wdata[1:0];
      if (regReq.addr == wold_pkg::OFS_PIN_CTRL) invert_ff <= regReq.wdata[0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_ctrl_readback;
    regReq.rd && regReq.addr == wold_pkg::OFS_WAKE_CTRL |=> regRdata == ctrl_ff;
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)
    else $error("wake control read back wrong");
  property p_led_pass;
    !route_ff[0] && !$past(reset) |=> indicatorPinOne == $past(indicatorFunc);
  endproperty
  a_led_pass: assert property (p_led_pass)
    else $error("indicator pin not passing its normal level");
  property p_irq_pass;
    !route_ff[1] && !$past(reset) |=> wakeOutOnIrqPin == $past(irqFunc_n);
  endproperty
  a_irq_pass: assert property (p_irq_pass)
    else $error("interrupt pin not passing its normal level");
  property p_idle_led;
    route_ff[0] && ctrl_ff[6:0] == 7'h00 |=> indicatorPinOne;
  endproperty
  a_idle_led: assert property (p_idle_led)
    else $error("indicator wake low with all sources off");
  property p_idle_irq;
    route_ff[1] && ctrl_ff[6:0] == 7'h00 |=> wakeOutOnIrqPin != $past(invert_ff);
  endproperty
  a_idle_irq: assert property (p_idle_irq)
    else $error("interrupt wake idle level wrong");
  property p_link_up_wake;
    route_ff[0] && ctrl_ff[0] && ctrl_ff[8:7] == 2'h0 && $rose(linkUp) |=> ##1 !indicatorPinOne;
  endproperty
  a_link_up_wake: assert property (p_link_up_wake)
    else $error("link up did not wake");
  property p_link_down_wake;
    route_ff[0] && ctrl_ff[1] && ctrl_ff[8:7] == 2'h0 && $fell(linkUp) |=> ##1 !indicatorPinOne;
  endproperty
  a_link_down_wake: assert property (p_link_down_wake)
    else $error("link down did not wake");
  property p_wake_holds;
    route_ff[0] && !indicatorPinOne && $stable(ctrl_ff) && $stable(route_ff) |=> !indicatorPinOne;
  endproperty
  a_wake_holds: assert property (p_wake_holds)
    else $error("wake released while its enable stayed set");
endmodule

//--- dv/wold_partner.sv
`timescale 1ns/10ps
module wold_partner (
  input  wire logic          clk_sys, // System clock
  output wold_pkg::wold_rx_t rxByte,  // Bytes toward the detector
  output logic               linkUp   // Link level seen by the detector
);
  // Line idle, link down
  initial begin
    rxByte = '0;
    linkUp = 1'b0;
  end

  // One frame; idle slots carry inverted data so no stale byte lingers
  task automatic send_frame(input logic [7:0] b[$], input int gapEvery);
    for (int i = 0; i < b.size(); i++) begin
      if (gapEvery > 0 && i > 0 && i % gapEvery == 0) begin
        rxByte <= '{1'b0, 1'b0, 1'b0, ~b[i - 1]};
        @(posedge clk_sys);
      end
      rxByte <= '{1'b1, i == 0, i == b.size() - 1, b[i]};
      @(posedge clk_sys);
    end
    rxByte <= '{1'b0, 1'b0, 1'b0, ~b[b.size() - 1]};
  endtask

  // Link level change, held after the edge
  task automatic set_link(input logic up);
    linkUp <= up;
    @(posedge clk_sys);
  endtask
endmodule

//--- dv/tb_wake_on_lan_detector.sv
`timescale 1ns/10ps
module tb_wake_on_lan_detector;
  logic                clk_sys;
  logic                reset;
  logic                indicatorFunc;
  logic                irqFunc_n;
  logic                indicatorPinOne;
  logic                wakeOutOnIrqPin;
  logic                linkUp;
  logic [15:0]         regRdata;
  logic [7:0]          base;
  logic [63:0]         msk;
  logic [31:0]         crc;
  logic [7:0]          fr[$];
  logic [7:0]          aq[$];
  wold_pkg::wold_req_t regReq;
  wold_pkg::wold_rx_t  rxByte;
  int                  err_count;
  int                  checks_done;

  wold_detector dut_u (.clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regRdata(regRdata),
    .rxByte(rxByte), .linkUp(linkUp), .indicatorFunc(indicatorFunc), .irqFunc_n(irqFunc_n),
    .indicatorPinOne(indicatorPinOne), .wakeOutOnIrqPin(wakeOutOnIrqPin));
  wold_partner peer_u (.clk_sys(clk_sys), .rxByte(rxByte), .linkUp(linkUp));

  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk_sys);
    regReq <= '0;
    @(posedge clk_sys);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    regReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk_sys);
    regReq <= '0;
    @(negedge clk_sys);
    check($sformatf("reg %h", a), regRdata, exp);
    @(posedge clk_sys);
  endtask

  // Pin levels once any wake has had time to reach them
  task automatic pins(input logic led, input logic irq);
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("indicatorPinOne", {15'h0000, indicatorPinOne}, {15'h0000, led});
    check("wakeOutOnIrqPin", {15'h0000, wakeOutOnIrqPin}, {15'h0000, irq});
    @(posedge clk_sys);
  endtask

  // Stray sync, a break, then sync and the station address repeated
  task automatic magic(input int reps);
    fr = '{8'h12, 8'hFF, 8'hFF, 8'h00};
    repeat (6) fr.push_back(8'hFF);
    repeat (reps) fr = {fr, 8'h0A, 8'h1B, 8'h2C, 8'h3D, 8'h4E, 8'h5F};
    fr.push_back(8'h55);
    peer_u.send_frame(fr, 7);
  endtask

  // Reflected CRC-32 over the masked bytes among the first 64
  function automatic logic [31:0] crc_of(input logic [7:0] b[$], input logic [63:0] m);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 64; i++)
      if (m[i]) begin
        c = c ^ {24'h000000, b[i]};
        for (int k = 0; k < 8; k++)
          c = c[0] ? (c >> 1) ^ 32'hEDB8_8320 : c >> 1;
      end
    return ~c;
  endfunction

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    regReq = '0;
    indicatorFunc = 1'b0;
    irqFunc_n = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    aq = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h10, 8'h2D};
    foreach (aq[i]) reg_rd(aq[i], 16'h0000);
    pins(1'b0, 1'b0);
    reg_wr(8'h0F, 16'hFFFF);
    reg_rd(8'h0F, 16'h0000);
    reg_wr(wold_pkg::OFS_ROUTE, 16'h0003);
    reg_wr(wold_pkg::OFS_PIN_CTRL, 16'h0001);
    pins(1'b1, 1'b0);
    reg_wr(wold_pkg::OFS_ADDR_LOW, 16'h4E5F);
    reg_wr(wold_pkg::OFS_ADDR_MID, 16'h2C3D);
    reg_wr(wold_pkg::OFS_ADDR_HIGH, 16'h0A1B);
    reg_rd(wold_pkg::OFS_ADDR_HIGH, 16'h0A1B);
    magic(16);
    pins(1'b1, 1'b0);
    reg_rd(wold_pkg::OFS_MAGIC_STAT, 16'h0001);
    reg_wr(wold_pkg::OFS_MAGIC_STAT, 16'h0001);
    reg_rd(wold_pkg::OFS_MAGIC_STAT, 16'h0000);
    reg_wr(wold_pkg::OFS_WAKE_CTRL, 16'h0040);
    magic(15);
    pins(1'b1, 1'b0);
    magic(16);
    pins(1'b0, 1'b1);
    reg_rd(wold_pkg::OFS_WAKE_STAT, 16'h0001);
    reg_wr(wold_pkg::OFS_WAKE_CTRL, 16'h0000);
    pins(1'b1, 1'b0);
    // Each custom type alone, type t under output-select code t
    for (int t = 0; t < 4; t++) begin
      base = 8'h10 + 8'(8 * t);
      fr = {};
      for (int i = 0; i < 70; i++) fr.push_back(8'(i * 7 + t));
      msk = 64'h8000_0100_0000_0000 | (64'h0000_0000_0010_0001 << t);
      crc = crc_of(fr, msk);
      reg_wr(base, crc[15:0]);
      reg_wr(base + 8'h01, crc[31:16]);
      for (int q = 0; q < 4; q++) reg_wr(base + 8'(2 + q), msk[16 * q +: 16]);
      reg_rd(base + 8'h01, crc[31:16]);
      reg_wr(wold_pkg::OFS_WAKE_CTRL, {7'h00, 2'(t), 7'h00} | (16'h0004 << t));
      fr[20 + t] = ~fr[20 + t];
      peer_u.send_frame(fr, t);
      pins(1'b1, 1'b0);
      fr[20 + t] = ~fr[20 + t];
      fr[30] = 8'hC3;
      fr[66] = 8'h99;
      peer_u.send_frame(fr, t);
      pins(1'(t >= 2), 1'(t != 1));
      reg_rd(wold_pkg::OFS_WAKE_STAT, 16'h0008 << t);
      reg_wr(wold_pkg::OFS_WAKE_CTRL, 16'h0000);
      pins(1'b1, 1'b0);
    end
    // Link events
    reg_wr(wold_pkg::OFS_WAKE_CTRL, 16'h0001);
    peer_u.set_link(1'b1);
    pins(1'b0, 1'b1);
    reg_rd(wold_pkg::OFS_LINK_STAT, 16'h0001);
    reg_wr(wold_pkg::OFS_WAKE_CTRL, 16'h0002);
    pins(1'b1, 1'b0);
    peer_u.set_link(1'b0);
    pins(1'b0, 1'b1);
    reg_rd(wold_pkg::OFS_LINK_STAT, 16'h0003);
    reg_wr(wold_pkg::OFS_LINK_STAT, 16'h0003);
    reg_rd(wold_pkg::OFS_LINK_STAT, 16'h0000);
    tally_and_finish();
  end
endmodule

bind wold_detector wold_checker #(.NUM_TYPES(NUM_TYPES)) chk_u (
  .clk_sys(clk_sys), .reset(reset), .regReq(regReq), .regRdata(regRdata), .rxByte(rxByte),
  .linkUp(linkUp), .indicatorFunc(indicatorFunc), .irqFunc_n(irqFunc_n),
  .indicatorPinOne(indicatorPinOne), .wakeOutOnIrqPin(wakeOutOnIrqPin));
